// ### rtl/stb_port.sv
// scan tap, test-mode enable and debug break pair
// assumes tck is the tester's clock, test_en, brk_req_n and on_chip_debug_mode asynchronous pins
`timescale 1ns/1ps
module stb_port (
   input wire logic clk_sys, // system clock
   input wire logic resetn, // async reset, low active
   input wire logic tck, // test clock
   input wire logic trst_n, // tap reset, low active
   input wire logic tms, // mode select
   input wire logic tdi, // test data in
   output logic tdo, // test data out
   output logic tdo_oe_n, // tdo enable, low drives
   input wire logic test_en, // chip test-mode pin
   output logic test_mode, // internal test mode
   input wire logic on_chip_debug_mode, // debug mode active
   input wire logic brk_req_n, // break-request pin
   output logic halt_req, // system halt
   input wire logic halt_release, // resume from debugger logic
   input wire logic dbg_trigger, // preselected trigger, pulse
   output logic brk_evt_n // break-event pin
);
   import stb_pkg::*;
   // ************************************************************
   // tap on tck
   // ************************************************************
   stb_tap_t st_r, st_nxt;
   logic [STB_IR_W-1:0] ir_r, ir_nxt, irs_r, irs_nxt;
   logic [31:0] dr_r, dr_nxt;
   logic tdo_r, tdo_nxt, oe_r, oe_nxt;

   // the id register is selected only by its own instruction, all else bypasses
   function automatic logic stb_sel_id(input logic [STB_IR_W-1:0] ir);
      return ir == STB_IR_IDCODE;
   endfunction : stb_sel_id

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         STB_RESET: st_nxt = tms ? STB_RESET : STB_IDLE;
         STB_IDLE: st_nxt = tms ? STB_SEL_DR : STB_IDLE;
         STB_SEL_DR: st_nxt = tms ? STB_SEL_IR : STB_CAP_DR;
         STB_CAP_DR: st_nxt = tms ? STB_EX1_DR : STB_SH_DR;
         STB_SH_DR: st_nxt = tms ? STB_EX1_DR : STB_SH_DR;
         STB_EX1_DR: st_nxt = tms ? STB_UPD_DR : STB_PAU_DR;
         STB_PAU_DR: st_nxt = tms ? STB_EX2_DR : STB_PAU_DR;
         STB_EX2_DR: st_nxt = tms ? STB_UPD_DR : STB_SH_DR;
         STB_UPD_DR: st_nxt = tms ? STB_SEL_DR : STB_IDLE;
         STB_SEL_IR: st_nxt = tms ? STB_RESET : STB_CAP_IR;
         STB_CAP_IR: st_nxt = tms ? STB_EX1_IR : STB_SH_IR;
         STB_SH_IR: st_nxt = tms ? STB_EX1_IR : STB_SH_IR;
         STB_EX1_IR: st_nxt = tms ? STB_UPD_IR : STB_PAU_IR;
         STB_PAU_IR: st_nxt = tms ? STB_EX2_IR : STB_PAU_IR;
         STB_EX2_IR: st_nxt = tms ? STB_UPD_IR : STB_SH_IR;
         STB_UPD_IR: st_nxt = tms ? STB_SEL_DR : STB_IDLE;
         default: st_nxt = STB_RESET;
      endcase
   end

   always_comb begin
      ir_nxt = ir_r;
      irs_nxt = irs_r;
      dr_nxt = dr_r;
      case (st_r)
         STB_RESET: ir_nxt = STB_IR_RESET;
         STB_CAP_IR: irs_nxt = STB_IR_CAPTURE;
         STB_SH_IR: irs_nxt = {tdi, irs_r[STB_IR_W-1:1]};
         STB_UPD_IR: ir_nxt = irs_r;
         STB_CAP_DR: dr_nxt = stb_sel_id(ir_r) ? STB_IDCODE_VAL : 32'h00000000;
         STB_SH_DR: begin
            // bypass is a one-bit path through bit 0
            if (stb_sel_id(ir_r)) dr_nxt = {tdi, dr_r[31:1]};
            else dr_nxt = {31'h00000000, tdi};
         end
         default: ;
      endcase
   end

   // rising tck samples tms/tdi; trst_n forces reset asynchronously
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         st_r <= STB_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // reset puts bypass back, so a stale id selection cannot survive trst_n
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_r <= STB_IR_RESET;
         irs_r <= 4'h0;
         dr_r <= 32'h00000000;
      end else begin
         ir_r <= ir_nxt;
         irs_r <= irs_nxt;
         dr_r <= dr_nxt;
      end
   end

   always_comb begin
      tdo_nxt = tdo_r;
      oe_nxt = 1'b1;
      if (st_r == STB_SH_IR) begin
         tdo_nxt = irs_r[0];
         oe_nxt = 1'b0;
      end else if (st_r == STB_SH_DR) begin
         tdo_nxt = dr_r[0];
         oe_nxt = 1'b0;
      end
   end

   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_r <= 1'b0;
         oe_r <= 1'b1;
      end else begin
         tdo_r <= tdo_nxt;
         oe_r <= oe_nxt;
      end
   end
   assign tdo = tdo_r;
   assign tdo_oe_n = oe_r;

   // ************************************************************
   // pin synchronisers on clk_sys
   // ************************************************************
   // pins are unsynchronised; debug mode is treated as asynchronous too
   logic [1:0] ten_s_r, ten_s_nxt, brk_s_r, brk_s_nxt, ocd_s_r, ocd_s_nxt;
   logic ocd_on;

   always_comb begin
      ten_s_nxt = {ten_s_r[0], test_en};
      brk_s_nxt = {brk_s_r[0], brk_req_n};
      ocd_s_nxt = {ocd_s_r[0], on_chip_debug_mode};
   end

   // break pin idles high, so its stages reset high to avoid a false edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ten_s_r <= 2'h0;
         brk_s_r <= 2'h3;
         ocd_s_r <= 2'h0;
      end else begin
         ten_s_r <= ten_s_nxt;
         brk_s_r <= brk_s_nxt;
         ocd_s_r <= ocd_s_nxt;
      end
   end

   // only the second stage is read downstream
   assign ocd_on = ocd_s_r[1];

   // ************************************************************
   // test mode
   // ************************************************************
   logic test_r, test_nxt;

   always_comb begin
      test_nxt = ten_s_r[1];
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         test_r <= 1'b0;
      end else begin
         test_r <= test_nxt;
      end
   end

   assign test_mode = test_r;

   // ************************************************************
   // break request and halt
   // ************************************************************
   logic brk_d_r, brk_d_nxt, halt_r, halt_nxt;

   always_comb begin
      brk_d_nxt = brk_s_r[1];
      halt_nxt = halt_r;
      if (halt_release) halt_nxt = 1'b0;
      // halt wins over a release in the same cycle
      if (ocd_on && brk_d_r && !brk_s_r[1]) halt_nxt = 1'b1;
      // leaving debug mode drops any pending halt
      if (!ocd_on) halt_nxt = 1'b0;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         brk_d_r <= 1'b1;
         halt_r <= 1'b0;
      end else begin
         brk_d_r <= brk_d_nxt;
         halt_r <= halt_nxt;
      end
   end

   assign halt_req = halt_r;

   // ************************************************************
   // break event pulse
   // ************************************************************
   logic evt_r, evt_nxt;
   logic [2:0] cnt_r, cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      evt_nxt = 1'b1;
      if (cnt_r != 3'h0) begin
         cnt_nxt = cnt_r - 3'h1;
         evt_nxt = 1'b0;
      end
      // low pulse long enough to be seen by a slow debug probe
      // a new trigger restarts the count rather than stretching it
      if (ocd_on && dbg_trigger) begin
         cnt_nxt = 3'(STB_BRK_PULSE - 1);
         evt_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         evt_r <= 1'b1;
         cnt_r <= 3'h0;
      end else begin
         evt_r <= evt_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign brk_evt_n = evt_r;
endmodule : stb_port

// ### rtl/stb_pkg.sv
// package for the scan test and break port
// assumes a system clock domain and a separate test clock domain
package stb_pkg;
   // ************************************************************
   // tap states
   // ************************************************************
   typedef enum logic [3:0] {
      STB_RESET, STB_IDLE, STB_SEL_DR, STB_CAP_DR, STB_SH_DR, STB_EX1_DR, STB_PAU_DR,
      STB_EX2_DR, STB_UPD_DR, STB_SEL_IR, STB_CAP_IR, STB_SH_IR, STB_EX1_IR, STB_PAU_IR,
      STB_EX2_IR, STB_UPD_IR
   } stb_tap_t;
   // ************************************************************
   // widths and codes
   // ************************************************************
   localparam int STB_IR_W = 4;
   localparam logic [3:0] STB_IR_CAPTURE = 4'h1;
   localparam logic [3:0] STB_IR_RESET = 4'hf;
   localparam logic [3:0] STB_IR_IDCODE = 4'h1;
   localparam logic [3:0] STB_IR_BYPASS = 4'hf;
   // arbitrary identification value
   localparam logic [31:0] STB_IDCODE_VAL = 32'h00000001;
   // break-event low pulse length in system clocks
   localparam int STB_BRK_PULSE = 4;
endpackage : stb_pkg

// ### verif/stb_port_checker.sv
// assertions on the ports of the scan test and break port
// assumes bind onto stb_port; all checks run on the system clock
`timescale 1ns/1ps
module stb_port_checker (
   input wire logic clk_sys, resetn, tck, trst_n, tms, tdi, tdo, tdo_oe_n, test_en,
   input wire logic test_mode, on_chip_debug_mode, brk_req_n, halt_req, halt_release,
   input wire logic dbg_trigger, brk_evt_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_quiet; brk_req_n [*5]; endsequence
   sequence s_evt; on_chip_debug_mode [*3] ##0 dbg_trigger; endsequence
   sequence s_brk; on_chip_debug_mode [*3] ##0 $fell(brk_req_n); endsequence
   a_test_follow: assert property (test_mode == $past(test_en, 3))
      else $error("test mode latency");
   a_halt_set: assert property (s_brk |-> ##[3:5] halt_req)
      else $error("no halt");
   a_halt_off: assert property ((!on_chip_debug_mode) [*4] |-> !halt_req)
      else $error("halt outside debug");
   a_halt_release: assert property (s_quiet ##0 halt_release |=> !halt_req)
      else $error("halt kept");
   a_evt_pulse: assert property (s_evt |=> !brk_evt_n [*4])
      else $error("event pulse short");
   a_evt_end: assert property ((!dbg_trigger) [*5] |-> brk_evt_n)
      else $error("event pulse long");
   a_evt_cause: assert property ($fell(brk_evt_n) |-> $past(dbg_trigger))
      else $error("event without trigger");
   a_trst_hold: assert property ((!trst_n) [*2] |-> tdo_oe_n && !tdo)
      else $error("tap active in reset");
endmodule : stb_port_checker
bind stb_port stb_port_checker stb_port_checker_i (.*);

// ### verif/stb_tester.sv
// scan tester model driving the tap pins
// assumes tck only toggles inside frames, tdi rests high (pull-up)
`timescale 1ns/1ps
module stb_tester (
   output logic tck, // test clock
   output logic tms, // mode select
   output logic tdi, // data to device
   output logic trst_n, // tap reset
   input wire logic tdo // data from device
);
   logic q;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b0;
   end
   // tdo is taken before the rise that shifts the next bit out
   task bit_io(input logic m, input logic b);
      tms = m;
      tdi = b;
      #16;
      q = tdo;
      tck = 1'b1;
      #16;
      tck = 1'b0;
   endtask : bit_io
   task set_trst(input logic v);
      trst_n = v;
   endtask : set_trst
   task shift(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
      dout = '0;
      bit_io(1'b1, 1'b0);
      if (ir) bit_io(1'b1, 1'b0);
      bit_io(1'b0, 1'b0);
      bit_io(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         bit_io(i == n - 1, din[i]);
         dout[i] = q;
      end
      bit_io(1'b1, 1'b0);
      bit_io(1'b0, 1'b1);
   endtask : shift
   task tms_reset;
      repeat (5) bit_io(1'b1, 1'b1);
      bit_io(1'b0, 1'b1);
   endtask : tms_reset
endmodule : stb_tester

// ### verif/stb_port_tb_top.sv
// self-checking bench for the scan test and break port
// assumes the tester model runs the tap in its own clock
`timescale 1ns/1ps
module stb_port_tb_top;
   import stb_pkg::*;
   logic clk_sys, resetn, test_en, on_chip_debug_mode, brk_req_n, halt_release, dbg_trigger;
   logic tck, trst_n, tms, tdi, tdo, tdo_oe_n, test_mode, halt_req, brk_evt_n;
   logic [31:0] d;
   int errors = 0, n_tests = 0;
   stb_tester stb_tester_i (.*);
   stb_port stb_port_i (.*);
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("unexpected at %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task test_done;
      $display("errors %0d of %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task t_tap;
      stb_tester_i.set_trst(1'b1);
      stb_tester_i.bit_io(1'b0, 1'b1);
      stb_tester_i.shift(1'b0, 32'h3, 2, d);
      chk(d, 32'h2);
      stb_tester_i.shift(1'b1, 32'(STB_IR_IDCODE), STB_IR_W, d);
      chk(d, 32'(STB_IR_CAPTURE));
      stb_tester_i.shift(1'b0, 32'h0, 32, d);
      chk(d, STB_IDCODE_VAL);
      stb_tester_i.tms_reset;
      stb_tester_i.shift(1'b0, 32'h3, 2, d);
      chk(d, 32'h2);
      stb_tester_i.shift(1'b1, 32'(STB_IR_IDCODE), STB_IR_W, d);
      stb_tester_i.set_trst(1'b0);
      repeat (3) begin
         stb_tester_i.bit_io(1'b0, 1'b1);
         chk(32'(tdo_oe_n), 32'h1);
      end
      stb_tester_i.set_trst(1'b1);
      stb_tester_i.bit_io(1'b0, 1'b1);
      stb_tester_i.shift(1'b0, 32'h3, 2, d);
      chk(d, 32'h2);
   endtask : t_tap
   task t_test;
      cyc(1);
      test_en <= 1'b1;
      cyc(4);
      @(negedge clk_sys);
      chk(32'(test_mode), 32'h1);
      cyc(1);
      test_en <= 1'b0;
      cyc(4);
      @(negedge clk_sys);
      chk(32'(test_mode), 32'h0);
   endtask : t_test
   task t_brk;
      cyc(1);
      on_chip_debug_mode <= 1'b1;
      cyc(4);
      brk_req_n <= 1'b0;
      cyc(6);
      @(negedge clk_sys);
      chk(32'(halt_req), 32'h1);
      cyc(1);
      brk_req_n <= 1'b1;
      cyc(5);
      halt_release <= 1'b1;
      cyc(1);
      halt_release <= 1'b0;
      @(negedge clk_sys);
      chk(32'(halt_req), 32'h0);
      cyc(1);
      on_chip_debug_mode <= 1'b0;
      cyc(4);
      brk_req_n <= 1'b0;
      cyc(6);
      @(negedge clk_sys);
      chk(32'(halt_req), 32'h0);
      cyc(1);
      brk_req_n <= 1'b1;
   endtask : t_brk
   task t_evt;
      for (int m = 1; m >= 0; m--) begin
         cyc(1);
         on_chip_debug_mode <= m[0];
         cyc(4);
         dbg_trigger <= 1'b1;
         cyc(1);
         dbg_trigger <= 1'b0;
         @(negedge clk_sys);
         chk(32'(brk_evt_n), 32'(!m[0]));
         cyc(5);
         @(negedge clk_sys);
         chk(32'(brk_evt_n), 32'h1);
      end
   endtask : t_evt
   initial begin
      clk_sys = 0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      resetn = 1'b0;
      test_en = 1'b0;
      on_chip_debug_mode = 1'b0;
      brk_req_n = 1'b1;
      halt_release = 1'b0;
      dbg_trigger = 1'b0;
      cyc(16);
      resetn <= 1'b1;
      t_tap;
      t_test;
      t_brk;
      t_evt;
      test_done;
   end
   // the whole run needs well under a tenth of this span
   initial begin
      #200000;
      errors++;
      test_done;
   end
endmodule : stb_port_tb_top
